/* src/lvdc_pkg.sv */
// Purpose: Shared constants and types of the low-voltage detect control block
// Assumes: 8-bit register port at 16-bit byte addresses, 250 MHz clock
// Notes:   Offsets, field positions, reset values and counts live here only
package lvdc_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int LEVEL_CODE_W = 4;
	localparam int PORT12_PINS = 5;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_DETECT_CTRL = 16'hFFBE;
	localparam logic [ADDR_W-1:0] OFF_LEVEL_SEL = 16'hFFBF;
	localparam logic [ADDR_W-1:0] OFF_PORT12_DIR = 16'hFF2C;
	localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 16'hFFA8;
	localparam logic [ADDR_W-1:0] OFF_INT_CTRL = 16'hFFA9;

	// Detect control fields
	localparam int BIT_BELOW = 0;
	localparam int BIT_MODE = 1;
	localparam int BIT_SRC = 2;
	localparam int BIT_ON = 7;

	// Reset cause and interrupt control fields
	localparam int BIT_CAUSE = 0;
	localparam int BIT_REQ = 0;
	localparam int BIT_MASK = 1;
	localparam int BIT_SETTLED = 2;

	// Values after reset, and the level code used for external sensing
	localparam logic [DATA_W-1:0] RST_LEVEL_SEL = 8'h00;
	localparam logic [DATA_W-1:0] RST_PORT12_DIR = 8'hFF;
	localparam logic [DATA_W-1:0] RST_INT_CTRL = 8'h02;
	localparam logic [LEVEL_CODE_W-1:0] EXT_LEVEL_CODE = 4'h0;

	// Fixed external threshold, for reference only
	localparam int EXT_THRESH_MV = 1210;

	// Comparator settling window
	localparam int CLK_MHZ = 250;
	localparam int STAB_TIME_US = 10;
	localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
	localparam int STAB_CNT_W = 12;

	typedef enum logic [1:0] {
		DET_OFF,
		DET_SETTLE,
		DET_RUN
	} lvdc_det_state_t;

endpackage

/* src/lvdc_sync.sv */
// Purpose: Two-stage synchroniser for the comparator output
// Assumes: Input is asynchronous to clk
// Notes:   First stage is read by the second stage only
`timescale 1ns/100ps
`default_nettype none
module lvdc_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_r;
	logic sync_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule // lvdc_sync
`default_nettype wire

/* src/lvdc_port_dir.sv */
// Purpose: Port 12 direction register and pin buffer enables
// Assumes: Write strobe already decoded for this register
// Notes:   Upper three bits are fixed at one
`timescale 1ns/100ps
`default_nettype none
module lvdc_port_dir (
	input  wire logic                                 clk,
	input  wire logic                                 any_rst,
	input  wire logic                                 wr_en,
	input  wire logic [lvdc_pkg::DATA_W-1:0]          wdata,
	output logic      [lvdc_pkg::DATA_W-1:0]          dir_value,
	output logic      [lvdc_pkg::PORT12_PINS-1:0]     dir_bits,
	output logic      [lvdc_pkg::PORT12_PINS-1:0]     oe_bits
);

	logic [lvdc_pkg::PORT12_PINS-1:0] dir_r;

	// RULE5 all inputs after reset
	always_ff @(posedge clk) begin
		if (any_rst) begin
			dir_r <= lvdc_pkg::RST_PORT12_DIR[lvdc_pkg::PORT12_PINS-1:0];
		end else if (wr_en) begin
			dir_r <= wdata[lvdc_pkg::PORT12_PINS-1:0];
		end
	end

	// RULE5 fixed ones above
	assign dir_value = {lvdc_pkg::RST_PORT12_DIR[lvdc_pkg::DATA_W-1:lvdc_pkg::PORT12_PINS], dir_r};
	assign dir_bits = dir_r;
	// RULE6 zero drives pin
	assign oe_bits = ~dir_r;

endmodule // lvdc_port_dir
`default_nettype wire

/* src/lvdc_top.sv */
// Purpose: Low-voltage detect control: flag, reset and interrupt modes, pin direction
// Assumes: Analog comparator gives CMP_BELOW high while the level is under threshold
// Notes:   Internal reset leaves mode bits intact; SYS_RST is every other reset
//
// Contract
// RULE1 - Software writes zero to upper level bits
// RULE2 - Software keeps level fixed while detector on
// RULE3 - External sensing uses fixed threshold, ignores code
// RULE4 - Software sets pin direction input for sensing
// RULE5 - Direction register resets to all ones
// RULE6 - Direction zero output, one input
// RULE7 - Reset mode supply: reset while below
// RULE8 - Reset mode external: reset while below
// RULE9 - Interrupt mode supply: interrupt both crossings
// RULE10 - Interrupt mode external: interrupt both crossings
// RULE11 - Bit 0 shows below-threshold state
// RULE12 - Mode bit 1, source bit 2
// RULE13 - Software supply start sequence with wait
// RULE14 - Software external start sequence with wait
// RULE15 - Software masks interrupt before enabling detector
// RULE16 - No reset when level good at mode set
// RULE17 - Software stops via 00H or ordered clears
// RULE18 - Detector reset recorded in cause bit 0
// RULE19 - Any reset sets interrupt mask
// RULE20 - Control bits survive detector reset only
// RULE21 - Flag drives interrupt line in interrupt mode
// RULE22 - Level code picks one of sixteen thresholds
// RULE23 - Bit 7 enables comparator; flag zero when off
// RULE24 - Comparator output synchronised in two stages
`timescale 1ns/100ps
`default_nettype none
module lvdc_top (
	input  wire logic                                 CLOCK,
	input  wire logic                                 SYS_RST,
	input  wire logic [lvdc_pkg::ADDR_W-1:0]          REG_ADDR,
	input  wire logic [lvdc_pkg::DATA_W-1:0]          REG_WDATA,
	input  wire logic                                 REG_WR,
	input  wire logic                                 REG_RD,
	output logic      [lvdc_pkg::DATA_W-1:0]          REG_RDATA,
	input  wire logic                                 CMP_BELOW,
	output logic                                      CMP_ENABLE,
	output logic                                      CMP_SRC_EXT,
	output logic      [lvdc_pkg::LEVEL_CODE_W-1:0]    CMP_LEVEL_CODE,
	output logic                                      LVD_RESET,
	output logic                                      LVD_INTERRUPT,
	output logic                                      LVD_INT_REQ,
	output logic                                      LVD_INT_MASK,
	output logic      [lvdc_pkg::PORT12_PINS-1:0]     P12_DIR,
	output logic      [lvdc_pkg::PORT12_PINS-1:0]     P12_OE
);

	logic                                  on_r;
	logic                                  mode_r;
	logic                                  src_r;
	logic [lvdc_pkg::LEVEL_CODE_W-1:0]     level_r;
	logic [lvdc_pkg::LEVEL_CODE_W-1:0]     cmp_level_r;
	logic                                  cmp_sync;
	logic                                  below_flag_r;
	logic                                  below_prev_r;
	logic                                  lvd_rst_r;
	logic                                  irq_line_r;
	logic                                  int_req_r;
	logic                                  int_mask_r;
	logic                                  cause_r;
	logic                                  settled_r;
	logic [lvdc_pkg::STAB_CNT_W-1:0]       stab_cnt_r;
	logic [lvdc_pkg::STAB_CNT_W-1:0]       stab_cnt_nxt;
	lvdc_pkg::lvdc_det_state_t             det_state_r;
	lvdc_pkg::lvdc_det_state_t             det_state_nxt;
	logic [lvdc_pkg::DATA_W-1:0]           rdata_r;
	logic [lvdc_pkg::DATA_W-1:0]           rd_mux;
	logic [lvdc_pkg::DATA_W-1:0]           dir_value;
	logic                                  any_rst;
	logic                                  wr_ctrl;
	logic                                  wr_level;
	logic                                  wr_dir;
	logic                                  wr_int;
	logic                                  rd_cause;
	logic                                  crossing;

	// Address decode shared by read and write paths
	function automatic logic hit(input logic [lvdc_pkg::ADDR_W-1:0] addr,
				input logic [lvdc_pkg::ADDR_W-1:0] off);
		hit = (addr == off);
	endfunction

	// Writes are dropped while the detector holds the chip in reset
	assign wr_ctrl = REG_WR && !lvd_rst_r && hit(REG_ADDR, lvdc_pkg::OFF_DETECT_CTRL);
	assign wr_level = REG_WR && !lvd_rst_r && hit(REG_ADDR, lvdc_pkg::OFF_LEVEL_SEL);
	assign wr_dir = REG_WR && !lvd_rst_r && hit(REG_ADDR, lvdc_pkg::OFF_PORT12_DIR);
	assign wr_int = REG_WR && !lvd_rst_r && hit(REG_ADDR, lvdc_pkg::OFF_INT_CTRL);
	assign rd_cause = REG_RD && hit(REG_ADDR, lvdc_pkg::OFF_RESET_CAUSE);
	assign any_rst = SYS_RST || lvd_rst_r;

	// RULE24 two stages, held clear while off: no stale level at enable
	lvdc_sync u_sync (
		.clk      (CLOCK),
		.rst      (SYS_RST || !on_r),
		.async_in (CMP_BELOW),
		.sync_out (cmp_sync)
	);

	lvdc_port_dir u_port_dir (
		.clk       (CLOCK),
		.any_rst   (any_rst),
		.wr_en     (wr_dir),
		.wdata     (REG_WDATA),
		.dir_value (dir_value),
		.dir_bits  (P12_DIR),
		.oe_bits   (P12_OE)
	);

	// RULE20 kept through detector reset
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			on_r <= 1'b0;
			mode_r <= 1'b0;
			src_r <= 1'b0;
		end else if (wr_ctrl) begin
			// RULE12 mode and source fields
			on_r <= REG_WDATA[lvdc_pkg::BIT_ON];
			mode_r <= REG_WDATA[lvdc_pkg::BIT_MODE];
			src_r <= REG_WDATA[lvdc_pkg::BIT_SRC];
		end
	end

	// Only the low four bits are stored; upper bits read zero
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			level_r <= lvdc_pkg::RST_LEVEL_SEL[lvdc_pkg::LEVEL_CODE_W-1:0];
		end else if (wr_level) begin
			level_r <= REG_WDATA[lvdc_pkg::LEVEL_CODE_W-1:0];
		end
	end

	// RULE3 external uses fixed reference
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			cmp_level_r <= lvdc_pkg::RST_LEVEL_SEL[lvdc_pkg::LEVEL_CODE_W-1:0];
		end else if (src_r) begin
			cmp_level_r <= lvdc_pkg::EXT_LEVEL_CODE;
		end else begin
			// RULE22 code to analog selector
			cmp_level_r <= level_r;
		end
	end

	// RULE23 flag cleared while off
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			below_flag_r <= 1'b0;
			below_prev_r <= 1'b0;
		end else begin
			// RULE11 live below-level state
			below_flag_r <= on_r && cmp_sync;
			below_prev_r <= below_flag_r;
		end
	end

	// Settle tracking only informs software; modes act at once
	always_comb begin
		det_state_nxt = det_state_r;
		stab_cnt_nxt = stab_cnt_r;
		unique case (det_state_r)
			lvdc_pkg::DET_OFF: begin
				stab_cnt_nxt = '0;
				if (on_r) begin
					det_state_nxt = lvdc_pkg::DET_SETTLE;
				end
			end
			lvdc_pkg::DET_SETTLE: begin
				stab_cnt_nxt = stab_cnt_r + 12'h001;
				if (!on_r) begin
					det_state_nxt = lvdc_pkg::DET_OFF;
				end else if (stab_cnt_r == 12'(lvdc_pkg::STAB_CYCLES - 1)) begin
					det_state_nxt = lvdc_pkg::DET_RUN;
				end
			end
			lvdc_pkg::DET_RUN: begin
				if (!on_r) begin
					det_state_nxt = lvdc_pkg::DET_OFF;
				end
			end
			default: begin
				det_state_nxt = lvdc_pkg::DET_OFF;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			det_state_r <= lvdc_pkg::DET_OFF;
			stab_cnt_r <= '0;
			settled_r <= 1'b0;
		end else begin
			det_state_r <= det_state_nxt;
			stab_cnt_r <= stab_cnt_nxt;
			settled_r <= (det_state_nxt == lvdc_pkg::DET_RUN);
		end
	end

	// RULE7 RULE8 reset while below
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			lvd_rst_r <= 1'b0;
		end else begin
			// RULE16 good level gives none
			lvd_rst_r <= on_r && mode_r && below_flag_r;
		end
	end

	// RULE21 flag onto request line
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			irq_line_r <= 1'b0;
		end else begin
			irq_line_r <= on_r && !mode_r && below_flag_r;
		end
	end

	// RULE9 RULE10 both crossings flagged
	assign crossing = on_r && !mode_r && (below_flag_r != below_prev_r);

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			int_req_r <= 1'b0;
		end else if (crossing) begin
			int_req_r <= 1'b1;
		end else if (wr_int && !REG_WDATA[lvdc_pkg::BIT_REQ]) begin
			int_req_r <= 1'b0;
		end
	end

	// RULE19 any reset masks
	always_ff @(posedge CLOCK) begin
		if (any_rst) begin
			int_mask_r <= lvdc_pkg::RST_INT_CTRL[lvdc_pkg::BIT_MASK];
		end else if (wr_int) begin
			int_mask_r <= REG_WDATA[lvdc_pkg::BIT_MASK];
		end
	end

	// RULE18 record detector reset
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			cause_r <= 1'b0;
		end else if (lvd_rst_r) begin
			cause_r <= 1'b1;
		end else if (rd_cause) begin
			// Cleared by reading, so a later reset is seen afresh
			cause_r <= 1'b0;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = '0;
		if (hit(REG_ADDR, lvdc_pkg::OFF_DETECT_CTRL)) begin
			rd_mux[lvdc_pkg::BIT_ON] = on_r;
			rd_mux[lvdc_pkg::BIT_SRC] = src_r;
			rd_mux[lvdc_pkg::BIT_MODE] = mode_r;
			rd_mux[lvdc_pkg::BIT_BELOW] = below_flag_r;
		end else if (hit(REG_ADDR, lvdc_pkg::OFF_LEVEL_SEL)) begin
			rd_mux[lvdc_pkg::LEVEL_CODE_W-1:0] = level_r;
		end else if (hit(REG_ADDR, lvdc_pkg::OFF_PORT12_DIR)) begin
			rd_mux = dir_value;
		end else if (hit(REG_ADDR, lvdc_pkg::OFF_RESET_CAUSE)) begin
			rd_mux[lvdc_pkg::BIT_CAUSE] = cause_r;
		end else if (hit(REG_ADDR, lvdc_pkg::OFF_INT_CTRL)) begin
			rd_mux[lvdc_pkg::BIT_REQ] = int_req_r;
			rd_mux[lvdc_pkg::BIT_MASK] = int_mask_r;
			rd_mux[lvdc_pkg::BIT_SETTLED] = settled_r;
		end
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			rdata_r <= '0;
		end else if (REG_RD) begin
			rdata_r <= rd_mux;
		end else begin
			rdata_r <= '0;
		end
	end

	assign REG_RDATA = rdata_r;
	assign CMP_ENABLE = on_r;
	assign CMP_SRC_EXT = src_r;
	assign CMP_LEVEL_CODE = cmp_level_r;
	assign LVD_RESET = lvd_rst_r;
	assign LVD_INTERRUPT = irq_line_r;
	assign LVD_INT_REQ = int_req_r;
	assign LVD_INT_MASK = int_mask_r;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	sequence s_below_held;
		(CMP_BELOW && on_r)[*3];
	endsequence

	sequence s_mode_set_good;
		$rose(mode_r) && !below_flag_r && !cmp_sync;
	endsequence

	sequence s_ctrl_read;
		REG_RD && hit(REG_ADDR, lvdc_pkg::OFF_DETECT_CTRL);
	endsequence

	// RULE24 latency of sync path
	chk_sync_flag_path: assert property (s_below_held |=> below_flag_r) // RULE24
		else $error("below flag missed a held comparator level");

	// RULE23 off forces flag low
	chk_flag_off_zero: assert property (!on_r |=> !below_flag_r) // RULE23
		else $error("below flag set while detector off");

	// RULE7 reset follows flag
	chk_reset_assert: assert property (on_r && mode_r && below_flag_r |=> LVD_RESET) // RULE7
		else $error("internal reset not raised while below");

	// RULE8 reset released above
	chk_reset_release: assert property (!below_flag_r |=> !LVD_RESET) // RULE8
		else $error("internal reset held with level good");

	// RULE16 mode set when good
	chk_no_reset_good: assert property (s_mode_set_good |=> !LVD_RESET ##1 !LVD_RESET) // RULE16
		else $error("reset produced although level was good");

	// RULE21 line mirrors flag
	chk_irq_line_flag: assert property (on_r && !mode_r |=> LVD_INTERRUPT == $past(below_flag_r)) // RULE21
		else $error("interrupt line does not follow below flag");

	// RULE9 both crossings latch
	chk_req_crossing: assert property (on_r && !mode_r && $changed(below_flag_r) |=> LVD_INT_REQ) // RULE9
		else $error("crossing did not set the request flag");

	// RULE19 mask after detector reset
	chk_mask_lvd_reset: assert property (LVD_RESET |=> LVD_INT_MASK) // RULE19
		else $error("mask not set by detector reset");

	// RULE20 control kept in reset
	chk_ctrl_kept: assert property (LVD_RESET |=> on_r && mode_r && $stable(src_r)) // RULE20
		else $error("control bits lost during detector reset");

	// RULE18 cause recorded
	chk_cause_set: assert property (LVD_RESET |=> cause_r) // RULE18
		else $error("detector reset not recorded");

	// RULE3 code masked external
	chk_ext_code: assert property (src_r |=> CMP_LEVEL_CODE == lvdc_pkg::EXT_LEVEL_CODE) // RULE3
		else $error("level code reached comparator in external mode");

	// RULE5 direction after reset
	chk_dir_reset: assert property (LVD_RESET |=> (&P12_DIR) && !(|P12_OE)) // RULE5
		else $error("direction register not all ones after reset");

	// RULE11 flag readable in bit 0
	chk_flag_read: assert property (s_ctrl_read |=> REG_RDATA[lvdc_pkg::BIT_BELOW] == $past(below_flag_r)) // RULE11
		else $error("read of bit 0 disagrees with flag");

endmodule // lvdc_top
`default_nettype wire

/* sim/lvdc_cmp_model.sv */
// Purpose: Behavioural analog comparator facing the detect control block
// Assumes: Levels given in millivolts by the bench
// Notes:   Output wanders while disabled; the block must mask it
`timescale 1ns/100ps
`default_nettype none
module lvdc_cmp_model (
	input  wire logic        clk,
	input  wire logic        enable,
	input  wire logic        src_ext,
	input  wire logic [3:0]  level_code,
	input  wire logic [12:0] supply_mv,
	input  wire logic [12:0] ext_mv,
	output logic             below
);
	localparam logic [12:0] LVL_MV [16] = '{13'h1090, 13'hFFA, 13'hF5A, 13'hEC4, 13'hE24, 13'hD8E, 13'hCF8,
		13'hC58, 13'hBC2, 13'hB22, 13'hA8C, 13'h9F6, 13'h956, 13'h8C0, 13'h820, 13'h78A};
	localparam logic [12:0] EXT_MV = 13'h4BA;
	logic idle_r = 1'b0;

	// Disabled output toggles, never a steady level
	always @(posedge clk) begin
		idle_r <= ~idle_r;
	end

	always_comb begin
		if (!enable)
			below = idle_r;
		else if (src_ext)
			below = ext_mv < EXT_MV;
		else
			below = supply_mv < LVL_MV[level_code];
	end
endmodule // lvdc_cmp_model
`default_nettype wire

/* sim/lvdc_top_tb.sv */
// Purpose: Self-checking bench of the low-voltage detect control block
// Assumes: Notes of expected reads queued by the register driver
// Notes:   Latency after a level change is fixed, so waits are fixed
`timescale 1ns/100ps
`default_nettype none
module lvdc_top_tb;
	localparam logic [15:0] A_CTL = lvdc_pkg::OFF_DETECT_CTRL;
	localparam logic [15:0] A_LVL = lvdc_pkg::OFF_LEVEL_SEL;
	localparam logic [15:0] A_DIR = lvdc_pkg::OFF_PORT12_DIR;
	localparam logic [15:0] A_CAU = lvdc_pkg::OFF_RESET_CAUSE;
	localparam logic [15:0] A_INT = lvdc_pkg::OFF_INT_CTRL;
	logic        CLOCK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic [15:0] REG_ADDR = 16'h0000;
	logic [7:0]  REG_WDATA = 8'h00;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [7:0]  REG_RDATA;
	logic        CMP_BELOW;
	logic        CMP_ENABLE;
	logic        CMP_SRC_EXT;
	logic [3:0]  CMP_LEVEL_CODE;
	logic        LVD_RESET;
	logic        LVD_INTERRUPT;
	logic        LVD_INT_REQ;
	logic        LVD_INT_MASK;
	logic [4:0]  P12_DIR;
	logic [4:0]  P12_OE;
	logic [12:0] supply_mv = 13'h1388;
	logic [12:0] ext_mv = 13'h07D0;
	logic [7:0]  exp_q[$];
	logic        rd_pend = 1'b0;
	logic [7:0]  rnd;
	logic [7:0]  ctl;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;

	always #2 CLOCK = ~CLOCK;

	lvdc_top dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CMP_BELOW(CMP_BELOW),
		.CMP_ENABLE(CMP_ENABLE), .CMP_SRC_EXT(CMP_SRC_EXT), .CMP_LEVEL_CODE(CMP_LEVEL_CODE),
		.LVD_RESET(LVD_RESET), .LVD_INTERRUPT(LVD_INTERRUPT), .LVD_INT_REQ(LVD_INT_REQ),
		.LVD_INT_MASK(LVD_INT_MASK), .P12_DIR(P12_DIR), .P12_OE(P12_OE));

	lvdc_cmp_model cmp_u (.clk(CLOCK), .enable(CMP_ENABLE), .src_ext(CMP_SRC_EXT),
		.level_code(CMP_LEVEL_CODE), .supply_mv(supply_mv), .ext_mv(ext_mv), .below(CMP_BELOW));

	task automatic report(input string msg);
		failures++;
		$display("BAD %0t %s", $time, msg);
	endtask

	task automatic tally_and_finish();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp)
			report($sformatf("%s got %h want %h", what, got, exp));
	endtask

	task automatic cmp_rd(input logic [7:0] exp);
		compares++;
		if (REG_RDATA !== exp)
			report($sformatf("read got %h want %h", REG_RDATA, exp));
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge CLOCK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		exp_q.push_back(exp);
		@(posedge CLOCK);
		REG_RD <= 1'b0;
	endtask

	// Two sync flops, flag and reset flop: six cycles covers all
	task automatic settle();
		repeat (6) @(posedge CLOCK);
		#1;
	endtask

	task automatic lvl(input logic ext, input logic low);
		if (ext)
			ext_mv = low ? 13'h01F4 : 13'h07D0;
		else
			supply_mv = low ? 13'h03E8 : 13'h1388;
		settle();
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge CLOCK) begin
		rd_pend <= REG_RD;
		cycles++;
		if (cycles == 20000) begin
			report("timeout");
			tally_and_finish();
		end
	end

	always @(negedge CLOCK) begin
		if (rd_pend) begin
			if (exp_q.size() == 0)
				report("read with no note");
			else
				cmp_rd(exp_q.pop_front());
		end
	end

	initial begin
		rnd = 8'($urandom(32'hC321));
		repeat (16) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		@(posedge CLOCK);
		#1;
		cmp_pin(8'(P12_DIR), 8'h1F, "dir reset");
		cmp_pin(8'(P12_OE), 8'h00, "oe reset");
		cmp_pin(8'(LVD_INT_MASK), 8'h01, "mask reset");
		rd(A_CTL, 8'h00);
		rd(A_LVL, 8'h00);
		rd(A_DIR, 8'hFF);
		rd(A_INT, 8'h02);
		rd(16'h0000, 8'h00);
		wr(A_DIR, rnd);
		wr(16'h0000, 8'h5A);
		rd(A_DIR, {3'b111, rnd[4:0]});
		#1;
		cmp_pin(8'(P12_OE), {3'b000, ~rnd[4:0]}, "oe");
		rnd = 8'($urandom());
		wr(A_LVL, {4'h0, rnd[3:0]});
		rd(A_LVL, {4'h0, rnd[3:0]});
		lvl(1'b0, 1'b1);
		rd(A_CTL, 8'h00);
		#1;
		cmp_pin(8'(LVD_INTERRUPT), 8'h00, "int off");
		lvl(1'b0, 1'b0);
		wr(A_CTL, 8'h80);
		repeat (lvdc_pkg::STAB_CYCLES) @(posedge CLOCK);
		rd(A_INT, 8'h06);
		for (int s = 0; s < 2; s++) begin
			ctl = s ? 8'h84 : 8'h80;
			wr(A_INT, 8'h02);
			wr(A_CTL, ctl);
			settle();
			cmp_pin(8'(CMP_LEVEL_CODE), s ? 8'h00 : {4'h0, rnd[3:0]}, "code");
			cmp_pin(8'(CMP_SRC_EXT), 8'(s), "src");
			cmp_pin(8'(CMP_ENABLE), 8'h01, "enable");
			lvl(s[0], 1'b1);
			cmp_pin(8'(LVD_INTERRUPT), 8'h01, "int low");
			cmp_pin(8'(LVD_INT_REQ), 8'h01, "req fall");
			rd(A_CTL, ctl | 8'h01);
			wr(A_INT, 8'h02);
			#1;
			cmp_pin(8'(LVD_INT_REQ), 8'h00, "req clr");
			lvl(s[0], 1'b0);
			cmp_pin(8'(LVD_INT_REQ), 8'h01, "req rise");
			cmp_pin(8'(LVD_INTERRUPT), 8'h00, "int high");
			cmp_pin(8'(LVD_RESET), 8'h00, "no rst int");
		end
		wr(A_CTL, 8'h00);
		for (int s = 0; s < 2; s++) begin
			ctl = s ? 8'h84 : 8'h80;
			wr(A_CTL, ctl);
			repeat (lvdc_pkg::STAB_CYCLES) @(posedge CLOCK);
			rd(A_CTL, ctl);
			wr(A_CTL, ctl | 8'h02);
			wr(A_INT, 8'h00);
			wr(A_DIR, s ? 8'h01 : 8'h00);
			settle();
			cmp_pin(8'(LVD_RESET), 8'h00, "rst good");
			cmp_pin(8'(LVD_INT_MASK), 8'h00, "mask open");
			lvl(s[0], 1'b1);
			cmp_pin(8'(LVD_RESET), 8'h01, "rst low");
			cmp_pin(8'(P12_DIR), 8'h1F, "dir rst");
			cmp_pin(8'(LVD_INT_MASK), 8'h01, "mask rst");
			wr(A_CTL, 8'h00);
			rd(A_CTL, ctl | 8'h03);
			lvl(s[0], 1'b0);
			cmp_pin(8'(LVD_RESET), 8'h00, "rst free");
			rd(A_CAU, 8'h01);
			rd(A_CAU, 8'h00);
			wr(A_CTL, 8'h00);
			rd(A_CTL, 8'h00);
		end
		wr(A_INT, 8'h00);
		wr(A_CTL, 8'h86);
		#1;
		cmp_pin(8'(LVD_INT_MASK), 8'h00, "mask before rst");
		@(posedge CLOCK);
		SYS_RST <= 1'b1;
		@(posedge CLOCK);
		SYS_RST <= 1'b0;
		rd(A_CTL, 8'h00);
		rd(A_LVL, 8'h00);
		settle();
		cmp_pin(8'(CMP_ENABLE), 8'h00, "enable sys rst");
		cmp_pin(8'(LVD_INT_MASK), 8'h01, "mask sys rst");
		if (exp_q.size() != 0)
			report("reads left over");
		tally_and_finish();
	end
endmodule // lvdc_top_tb
`default_nettype wire
